// ### safety_selftest_launch_ctrl.sv
// Launch control and status of the safety self-tests, plus the safety monitor enables
`timescale 1ns/1ns

module safety_selftest_launch_ctrl (
    // Clock and resets
    input wire logic core_clk,
    input wire logic srst,
    input wire logic device_reset,
    // Register command port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [1:0] reg_sel,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    output logic reg_rvalid_q,
    // Write locks
    input wire logic selftest_write_lock,
    input wire logic ctrl_write_lock,
    // Device operating state
    input wire logic [1:0] op_state,
    // Test engines, one lane per launch bit
    output logic [5:0] test_start_q,
    input wire logic [5:0] test_done,
    input wire logic [5:0] test_fail,
    // Enable pin level requested by the device
    input wire logic enable_drive_request,
    output logic enable_drive_pin_q,
    // Launch side effects: diagnostic state mask and timer, memory CRC error force
    output logic diag_mask_clear_q,
    output logic diag_timer_keep_q,
    output logic nvm_crc_error_force_q,
    // Safety monitor enables
    output logic config_crc_enable_q,
    output logic enable_drive_output_enable_q,
    output logic controller_error_monitor_enable_q,
    output logic diag_leave_request_q
);

    logic [5:0] busy;          // Launch bits as seen by software
    logic [5:0] start;         // Start pulses from the slots
    logic [5:0] finish;        // Completion pulses from the slots
    logic [5:0] launch;        // Accepted one-writes per bit
    logic launch_wr;           // Accepted write to the launch register
    logic enables_wr;          // Accepted write to the enables register
    logic state_ok;            // Logic self-test may start
    logic [7:0] enables_q;     // safety_monitor_enables storage
    logic [7:0] status_q;      // selftest_error_status storage
    logic [5:0] fail_seen_q;   // Failure seen during each running test
    logic hold_pin_q;          // Enable pin frozen during a run
    logic pin_level_q;         // Frozen enable pin level
    logic [1:0] op_prev_q;     // Operating state one cycle ago
    logic [7:0] rdata_d;       // Read mux
    // Distance from a check's launch bit to its status bit
    localparam int MON_OFS = selftest_launch_pkg::ST_PIN_MON - selftest_launch_pkg::BIT_PIN_MON;

    // Register write qualification with the write locks
    assign launch_wr = reg_wr_en && (reg_sel == selftest_launch_pkg::SEL_LAUNCH)
                       && !selftest_write_lock;
    assign enables_wr = reg_wr_en && (reg_sel == selftest_launch_pkg::SEL_ENABLES)
                        && !ctrl_write_lock;
    assign state_ok = (op_state == selftest_launch_pkg::OP_DIAG)
                      || (op_state == selftest_launch_pkg::OP_ACTIVE)
                      || (op_state == selftest_launch_pkg::OP_SAFE);

    // Per-bit launch requests; reserved bits never reach a slot
    always_comb begin
        launch = reg_wdata[5:0] & selftest_launch_pkg::LAUNCH_MASK[5:0];
        if (!launch_wr) begin
            launch = 6'h00;
        end
        if (!state_ok) begin
            launch[selftest_launch_pkg::BIT_LOGIC_SELFTEST] = 1'b0;
        end
    end

    // One launch slot per test, busy flag clears on completion
    for (genvar i = 0; i < selftest_launch_pkg::NUM_TESTS; i++) begin : g_slot
        test_launch_slot u_slot (
            .core_clk(core_clk),
            .srst(srst),
            .device_reset(device_reset),
            .launch(launch[i]),
            .done(test_done[i]),
            .busy_q(busy[i]),
            .start_q(start[i]),
            .finish_q(finish[i])
        );
    end

    // Start pulses to the engines, registered once more for clean outputs
    always_ff @(posedge core_clk) begin
        if (srst || device_reset) begin
            test_start_q <= 6'h00;
        end else begin
            test_start_q <= start;
        end
    end

    // Collect engine failure reports while a test runs; a relaunch starts afresh
    always_ff @(posedge core_clk) begin
        if (srst || device_reset) begin
            fail_seen_q <= 6'h00;
        end else begin
            fail_seen_q <= (fail_seen_q & ~start) | (test_fail & busy);
        end
    end

    // Status register: relaunch clears a test's bits, completion latches its result
    always_ff @(posedge core_clk) begin
        if (srst || device_reset) begin
            status_q <= selftest_launch_pkg::STATUS_RESET;
        end else begin
            if (start[selftest_launch_pkg::BIT_LOGIC_SELFTEST]) begin
                status_q[selftest_launch_pkg::ST_RUN_DONE] <= 1'b0;
                status_q[selftest_launch_pkg::ST_LOGIC_SELF_TEST_ERR] <= 1'b0;
            end
            if (start[selftest_launch_pkg::BIT_SELFTEST_CHECK]) begin
                status_q[selftest_launch_pkg::ST_CHECK_DONE] <= 1'b0;
                status_q[selftest_launch_pkg::ST_LOGIC_SELF_TEST_ERR] <= 1'b0;
            end
            // Run result: D1 done, D0 failure seen
            if (finish[selftest_launch_pkg::BIT_LOGIC_SELFTEST]) begin
                status_q[selftest_launch_pkg::ST_RUN_DONE] <= 1'b1;
                status_q[selftest_launch_pkg::ST_LOGIC_SELF_TEST_ERR] <=
                    fail_seen_q[selftest_launch_pkg::BIT_LOGIC_SELFTEST];
            end
            // Check result: D2 done, D0 shows the forced error was caught
            if (finish[selftest_launch_pkg::BIT_SELFTEST_CHECK]) begin
                status_q[selftest_launch_pkg::ST_CHECK_DONE] <= 1'b1;
                status_q[selftest_launch_pkg::ST_LOGIC_SELF_TEST_ERR] <=
                    fail_seen_q[selftest_launch_pkg::BIT_SELFTEST_CHECK];
            end
            // Monitor and CRC checks: bit set when the check failed
            for (int t = selftest_launch_pkg::BIT_PIN_MON; t <= selftest_launch_pkg::BIT_CFG_CRC;
                 t++) begin
                if (start[t]) begin
                    status_q[t + MON_OFS] <= 1'b0;
                end else if (finish[t]) begin
                    status_q[t + MON_OFS] <= fail_seen_q[t];
                end
            end
        end
    end

    // Memory CRC error flag is forced for the whole memory check
    always_ff @(posedge core_clk) begin
        if (srst || device_reset) begin
            nvm_crc_error_force_q <= 1'b0;
        end else begin
            nvm_crc_error_force_q <= busy[selftest_launch_pkg::BIT_NVM_CRC]
                                     && !finish[selftest_launch_pkg::BIT_NVM_CRC];
        end
    end

    // Diagnostic launch: one-cycle mask clear, timer kept running through the run
    always_ff @(posedge core_clk) begin
        if (srst || device_reset) begin
            diag_mask_clear_q <= 1'b0;
            diag_timer_keep_q <= 1'b0;
        end else begin
            diag_mask_clear_q <= start[selftest_launch_pkg::BIT_LOGIC_SELFTEST]
                                 && (op_state == selftest_launch_pkg::OP_DIAG);
            if (start[selftest_launch_pkg::BIT_LOGIC_SELFTEST]
                && (op_state == selftest_launch_pkg::OP_DIAG)) begin
                diag_timer_keep_q <= 1'b1;
            end else if (finish[selftest_launch_pkg::BIT_LOGIC_SELFTEST]) begin
                diag_timer_keep_q <= 1'b0;
            end
        end
    end

    // Active or safe launch freezes the enable pin until the run completes
    always_ff @(posedge core_clk) begin
        if (srst || device_reset) begin
            hold_pin_q <= 1'b0;
            pin_level_q <= 1'b0;
        end else if (launch[selftest_launch_pkg::BIT_LOGIC_SELFTEST]
                     && !busy[selftest_launch_pkg::BIT_LOGIC_SELFTEST]
                     && (op_state != selftest_launch_pkg::OP_DIAG)) begin
            hold_pin_q <= 1'b1;
            pin_level_q <= enable_drive_pin_q;
        end else if (finish[selftest_launch_pkg::BIT_LOGIC_SELFTEST]) begin
            hold_pin_q <= 1'b0;
        end
    end

    // Enable pin follows the device request gated by the drive enable, unless frozen
    always_ff @(posedge core_clk) begin
        if (srst || device_reset) begin
            enable_drive_pin_q <= 1'b0;
        end else if (hold_pin_q) begin
            enable_drive_pin_q <= pin_level_q;
        end else begin
            enable_drive_pin_q <= enable_drive_request
                                  && enables_q[selftest_launch_pkg::EN_DRIVE];
        end
    end

    // Track the operating state to spot transitions
    always_ff @(posedge core_clk) begin
        if (srst || device_reset) begin
            op_prev_q <= selftest_launch_pkg::OP_OTHER;
        end else begin
            op_prev_q <= op_state;
        end
    end

    // Safety monitor enables: lock-gated writes, both resets restore it
    always_ff @(posedge core_clk) begin
        if (srst || device_reset) begin
            enables_q <= selftest_launch_pkg::ENABLES_RESET;
        end else begin
            if (enables_wr) begin
                enables_q <= reg_wdata & selftest_launch_pkg::ENABLES_MASK;
                // Leave request only takes in the diagnostic state
                if (op_state != selftest_launch_pkg::OP_DIAG) begin
                    enables_q[selftest_launch_pkg::EN_DIAG_LEAVE] <= 1'b0;
                end
            end
            // Leaving the diagnostic state drops the leave request
            if (op_prev_q == selftest_launch_pkg::OP_DIAG
                && op_state != selftest_launch_pkg::OP_DIAG) begin
                enables_q[selftest_launch_pkg::EN_DIAG_LEAVE] <= 1'b0;
            end
            // Every cycle in the safe state clears the drive enable
            if (op_state == selftest_launch_pkg::OP_SAFE) begin
                enables_q[selftest_launch_pkg::EN_DRIVE] <= 1'b0;
            end
        end
    end

    // Enable fields out
    assign config_crc_enable_q = enables_q[selftest_launch_pkg::EN_CFG_CRC];
    assign enable_drive_output_enable_q = enables_q[selftest_launch_pkg::EN_DRIVE];
    assign controller_error_monitor_enable_q = enables_q[selftest_launch_pkg::EN_ERR_MON];
    assign diag_leave_request_q = enables_q[selftest_launch_pkg::EN_DIAG_LEAVE];

    // Read mux; reserved bits and unmapped selects read zero
    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_sel)
            selftest_launch_pkg::SEL_LAUNCH: rdata_d = {2'h0, busy};
            selftest_launch_pkg::SEL_ENABLES: rdata_d = enables_q;
            selftest_launch_pkg::SEL_STATUS: rdata_d = status_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // Registered read answer one cycle after the request
    always_ff @(posedge core_clk) begin
        if (srst || device_reset) begin
            reg_rdata_q <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata_q <= rdata_d;
            end
        end
    end

endmodule : safety_selftest_launch_ctrl

// ### safety_selftest_launch_ctrl_tb.sv
// Self-checking bench for the self-test launch controller
`timescale 1ns/1ns
module safety_selftest_launch_ctrl_tb;
    logic core_clk, srst, device_reset, reg_wr_en, reg_rd_en, reg_rvalid_q;
    logic [1:0] reg_sel, op_state;
    logic [7:0] reg_wdata, reg_rdata_q, delay;
    logic selftest_write_lock, ctrl_write_lock, enable_drive_request, enable_drive_pin_q;
    logic [5:0] test_start_q, test_done, test_fail, fail_mask;
    logic diag_mask_clear_q, diag_timer_keep_q, nvm_crc_error_force_q, config_crc_enable_q;
    logic enable_drive_output_enable_q, controller_error_monitor_enable_q, diag_leave_request_q;
    logic [31:0] seed = 32'hFF62D63A; // Random source state
    logic [31:0] v; // Current random word
    logic [7:0] exp_q [$]; // Expected read data, oldest first
    int errors = 0;
    int n_checks = 0;

    safety_selftest_launch_ctrl dut_u (.core_clk(core_clk), .srst(srst),
        .device_reset(device_reset), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .reg_rvalid_q(reg_rvalid_q), .selftest_write_lock(selftest_write_lock),
        .ctrl_write_lock(ctrl_write_lock), .op_state(op_state), .test_start_q(test_start_q),
        .test_done(test_done), .test_fail(test_fail), .enable_drive_request(enable_drive_request),
        .enable_drive_pin_q(enable_drive_pin_q), .diag_mask_clear_q(diag_mask_clear_q),
        .diag_timer_keep_q(diag_timer_keep_q), .nvm_crc_error_force_q(nvm_crc_error_force_q),
        .config_crc_enable_q(config_crc_enable_q),
        .enable_drive_output_enable_q(enable_drive_output_enable_q),
        .controller_error_monitor_enable_q(controller_error_monitor_enable_q),
        .diag_leave_request_q(diag_leave_request_q));
    selftest_engine_model engine_u (.core_clk(core_clk), .srst(srst), .start(test_start_q),
        .delay(delay), .fail_mask(fail_mask), .done(test_done), .fail(test_fail));

    // 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Xorshift step
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Expected status after one test k with outcome f
    function automatic logic [7:0] status_of(input int k, input logic f);
        case (k)
            0: return {6'h00, 1'b1, f};
            5: return {5'h00, 1'b1, 1'b0, f};
            default: return {7'h00, f} << (k + 2);
        endcase
    endfunction : status_of

    // Compare read data
    task automatic chk_read(input string name, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, e, g);
        end
    endtask : chk_read

    // Compare a single output level
    task automatic chk_pin(input string name, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %b seen %b", name, e, g);
        end
    endtask : chk_pin

    // Closing report
    task give_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // Drop strobes and let n cycles pass
    task automatic pause(input int n);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        repeat (n) @(negedge core_clk);
    endtask : pause

    // Register write, one cycle
    task automatic wr(input logic [1:0] sel, input logic [7:0] data);
        reg_sel = sel;
        reg_wdata = data;
        reg_rd_en = 1'b0;
        reg_wr_en = 1'b1;
        @(negedge core_clk);
    endtask : wr

    // Register read, expectation queued for the watcher
    task automatic rd(input logic [1:0] sel, input logic [7:0] e);
        exp_q.push_back(e);
        reg_sel = sel;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b1;
        @(negedge core_clk);
    endtask : rd

    // Device reset pulse
    task automatic dev_reset();
        device_reset = 1'b1;
        pause(2);
        device_reset = 1'b0;
    endtask : dev_reset

    // Bounded wait for an engine completion
    task automatic wait_done(input int k);
        int i;
        pause(1);
        for (i = 0; i < 60 && test_done[k] !== 1'b1; i++) @(negedge core_clk);
        if (i == 60) begin
            errors++;
            $display("unexpected completion %0d: expected done seen none", k);
            give_verdict();
        end
        pause(2);
    endtask : wait_done

    // Watcher takes the oldest expectation for each read answer
    initial forever begin
        @(negedge core_clk);
        if (reg_rvalid_q === 1'b1) begin
            chk_read("read data", exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, reg_rdata_q);
        end
    end

    // Main sequence
    initial begin
        srst = 1'b1;
        device_reset = 1'b0;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_sel = 2'h0;
        reg_wdata = 8'h00;
        selftest_write_lock = 1'b0;
        ctrl_write_lock = 1'b0;
        op_state = selftest_launch_pkg::OP_DIAG;
        enable_drive_request = 1'b1;
        delay = 8'h0A;
        fail_mask = 6'h00;
        repeat (5) @(negedge core_clk);
        srst = 1'b0;
        // Reset values, unmapped select included
        for (int s = 0; s < 4; s++) rd(s[1:0], 8'h00);
        // Enables: open write, locked write, device reset
        v = rnd();
        wr(selftest_launch_pkg::SEL_ENABLES, v[7:0]);
        rd(selftest_launch_pkg::SEL_ENABLES, v[7:0] & selftest_launch_pkg::ENABLES_MASK);
        ctrl_write_lock = 1'b1;
        wr(selftest_launch_pkg::SEL_ENABLES, ~v[7:0]);
        rd(selftest_launch_pkg::SEL_ENABLES, v[7:0] & selftest_launch_pkg::ENABLES_MASK);
        chk_pin("config crc enable", v[4], config_crc_enable_q);
        ctrl_write_lock = 1'b0;
        wr(2'h3, 8'hFF);
        dev_reset();
        rd(selftest_launch_pkg::SEL_ENABLES, 8'h00);
        // Locked launch writes are dropped
        selftest_write_lock = 1'b1;
        wr(selftest_launch_pkg::SEL_LAUNCH, 8'h3F);
        rd(selftest_launch_pkg::SEL_LAUNCH, 8'h00);
        selftest_write_lock = 1'b0;
        // Each test alone in the active state, slow engine, random outcome
        op_state = selftest_launch_pkg::OP_ACTIVE;
        for (int k = 0; k < 6; k++) begin
            v = rnd();
            fail_mask = v[5:0];
            delay = 8'h08 + {5'h00, v[10:8]};
            dev_reset();
            wr(selftest_launch_pkg::SEL_ENABLES, 8'h08);
            pause(1);
            wr(selftest_launch_pkg::SEL_LAUNCH, 8'h01 << k);
            rd(selftest_launch_pkg::SEL_LAUNCH, 8'h01 << k);
            pause(2);
            if (k == 3) chk_pin("nvm crc force", 1'b1, nvm_crc_error_force_q);
            enable_drive_request = ~enable_drive_request;
            pause(2);
            chk_pin("enable pin", (k == 0) ^ enable_drive_request, enable_drive_pin_q);
            wait_done(k);
            pause(1);
            chk_pin("enable pin", enable_drive_request, enable_drive_pin_q);
            rd(selftest_launch_pkg::SEL_LAUNCH, 8'h00);
            rd(selftest_launch_pkg::SEL_STATUS, status_of(k, fail_mask[k]));
        end
        // Run in the diagnostic state keeps the timeout timer alive
        op_state = selftest_launch_pkg::OP_DIAG;
        dev_reset();
        wr(selftest_launch_pkg::SEL_LAUNCH, 8'h01);
        pause(3);
        chk_pin("diag timer keep", 1'b1, diag_timer_keep_q);
        wait_done(0);
        chk_pin("diag timer keep", 1'b0, diag_timer_keep_q);
        // All bits at once outside the run states, prompt engine
        op_state = selftest_launch_pkg::OP_OTHER;
        v = rnd();
        fail_mask = v[5:0];
        delay = 8'h01;
        dev_reset();
        wr(selftest_launch_pkg::SEL_LAUNCH, 8'hFF);
        rd(selftest_launch_pkg::SEL_LAUNCH, 8'h3E);
        wait_done(5);
        rd(selftest_launch_pkg::SEL_STATUS, {1'b0, fail_mask[4:1], 2'b10, fail_mask[5]});
        rd(selftest_launch_pkg::SEL_LAUNCH, 8'h00);
        pause(3);
        give_verdict();
    end
endmodule : safety_selftest_launch_ctrl_tb

// ### safety_selftest_launch_monitor.sv
// Concurrent checks on the ports of the self-test launch controller
`timescale 1ns/1ns
module safety_selftest_launch_monitor (
    // Clock and resets
    input wire logic core_clk,
    input wire logic srst,
    input wire logic device_reset,
    // Register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [1:0] reg_sel,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_q,
    input wire logic reg_rvalid_q,
    input wire logic ctrl_write_lock,
    input wire logic [1:0] op_state,
    // Launch side effects and safety monitor enables
    input wire logic [5:0] test_start_q,
    input wire logic enable_drive_pin_q,
    input wire logic diag_mask_clear_q,
    input wire logic diag_timer_keep_q,
    input wire logic nvm_crc_error_force_q,
    input wire logic config_crc_enable_q,
    input wire logic controller_error_monitor_enable_q
);
    // One clock domain, both resets silence the checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst || device_reset);

    read_answer_a: assert property (reg_rvalid_q == $past(reg_rd_en))
        else $error("late read answer");
    rdata_hold_a: assert property (!reg_rvalid_q && !$past(srst) && !$past(device_reset)
        |-> $stable(reg_rdata_q)) else $error("read data moved");
    launch_reserved_a: assert property (reg_rvalid_q && $past(reg_sel) == selftest_launch_pkg::SEL_LAUNCH
        |-> (reg_rdata_q & ~selftest_launch_pkg::LAUNCH_MASK) == 8'h00)
        else $error("reserved bits set");
    unmapped_read_a: assert property (reg_rvalid_q && $past(reg_sel) == 2'h3
        |-> reg_rdata_q == 8'h00) else $error("unmapped read nonzero");
    start_pulse_a: assert property (|test_start_q
        |=> (test_start_q & $past(test_start_q)) == 6'h00) else $error("long start");
    diag_launch_a: assert property (test_start_q[0] && op_state == selftest_launch_pkg::OP_DIAG
        |-> diag_mask_clear_q && diag_timer_keep_q)
        else $error("diag launch effects missing");
    mask_source_a: assert property (diag_mask_clear_q |-> test_start_q[0])
        else $error("stray mask clear");
    nvm_force_a: assert property (test_start_q[3] |-> ##[0:2] nvm_crc_error_force_q)
        else $error("crc flag not forced");
    pin_freeze_a: assert property (test_start_q[0] && op_state == selftest_launch_pkg::OP_ACTIVE
        |=> $stable(enable_drive_pin_q) [*2])
        else $error("pin moved");
    enables_write_a: assert property (reg_wr_en && reg_sel == selftest_launch_pkg::SEL_ENABLES
        && !ctrl_write_lock |=> controller_error_monitor_enable_q == $past(reg_wdata[2])
        && config_crc_enable_q == $past(reg_wdata[4])) else $error("enables write lost");
    enables_lock_a: assert property (reg_wr_en && reg_sel == selftest_launch_pkg::SEL_ENABLES
        && ctrl_write_lock |=> $stable(config_crc_enable_q))
        else $error("locked write took");

    // Main scenarios reached
    cover property (test_start_q[0] && op_state == selftest_launch_pkg::OP_DIAG);
    cover property (test_start_q[3]);
    cover property (reg_wr_en && ctrl_write_lock);
endmodule : safety_selftest_launch_monitor

bind safety_selftest_launch_ctrl safety_selftest_launch_monitor mon_u (
    .core_clk(core_clk), .srst(srst), .device_reset(device_reset), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .ctrl_write_lock(ctrl_write_lock), .op_state(op_state),
    .test_start_q(test_start_q), .enable_drive_pin_q(enable_drive_pin_q),
    .diag_mask_clear_q(diag_mask_clear_q), .diag_timer_keep_q(diag_timer_keep_q),
    .nvm_crc_error_force_q(nvm_crc_error_force_q), .config_crc_enable_q(config_crc_enable_q),
    .controller_error_monitor_enable_q(controller_error_monitor_enable_q)
);

// ### selftest_engine_model.sv
// Behavioural model of the six test engines behind the launch lanes
`timescale 1ns/1ns
module selftest_engine_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Start pulses from the launcher
    input wire logic [5:0] start,
    // Run length and outcome chosen by the bench
    input wire logic [7:0] delay,
    input wire logic [5:0] fail_mask,
    // Completion and failure lines
    output logic [5:0] done,
    output logic [5:0] fail
);
    logic [5:0][7:0] count_q; // Cycles left per engine, zero when idle
    // Count each run down and pulse done on its last cycle
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 6; i++) begin
            done[i] <= 1'b0;
            if (srst) begin
                count_q[i] <= 8'h00;
            end else if (start[i]) begin
                count_q[i] <= delay;
            end else if (count_q[i] == 8'h01) begin
                count_q[i] <= 8'h00;
                done[i] <= 1'b1;
            end else if (count_q[i] != 8'h00) begin
                count_q[i] <= count_q[i] - 8'h01;
            end
        end
    end
    // Failure is reported together with completion only
    assign fail = done & fail_mask;
endmodule : selftest_engine_model

// ### selftest_launch_pkg.sv
// Register selects, field positions, reset values and state codes for the self-test launcher
package selftest_launch_pkg;

    // Register selects on the command port
    localparam logic [1:0] SEL_LAUNCH = 2'h0;   // self_test_launch_control
    localparam logic [1:0] SEL_ENABLES = 2'h1;  // safety_monitor_enables
    localparam logic [1:0] SEL_STATUS = 2'h2;   // selftest_error_status

    // Number of launch bits in self_test_launch_control
    localparam int NUM_TESTS = 6;

    // Launch bit positions
    localparam int BIT_LOGIC_SELFTEST = 0;      // logic_selftest_launch
    localparam int BIT_PIN_MON = 1;             // enable_pin_monitor_check_launch
    localparam int BIT_RESET_MON = 2;           // reset_pin_monitor_check_launch
    localparam int BIT_NVM_CRC = 3;             // nvm_crc_check_launch
    localparam int BIT_CFG_CRC = 4;             // config_crc_check_launch
    localparam int BIT_SELFTEST_CHECK = 5;      // selftest_check_launch

    // Writable masks, reserved bits excluded
    localparam logic [7:0] LAUNCH_MASK = 8'h3F;
    localparam logic [7:0] ENABLES_MASK = 8'h1D;

    // safety_monitor_enables field positions
    localparam int EN_DIAG_LEAVE = 0;           // diag_leave_request
    localparam int EN_ERR_MON = 2;              // controller_error_monitor_enable
    localparam int EN_DRIVE = 3;                // enable_drive_output_enable
    localparam int EN_CFG_CRC = 4;              // continuous configuration CRC enable

    // selftest_error_status bit positions
    localparam int ST_LOGIC_SELF_TEST_ERR = 0;            // logic self-test error seen
    localparam int ST_RUN_DONE = 1;             // logic self-test run completed
    localparam int ST_CHECK_DONE = 2;           // self-test check completed
    localparam int ST_PIN_MON = 3;              // pin monitor check missed the mismatch
    localparam int ST_RESET_MON = 4;            // reset monitor check missed the mismatch
    localparam int ST_NVM_CRC = 5;              // memory CRC check missed the error
    localparam int ST_CFG_CRC = 6;              // configuration CRC check missed the error

    // Reset values
    localparam logic [7:0] LAUNCH_RESET = 8'h00;
    localparam logic [7:0] ENABLES_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Operating state codes reported by the device state machine
    typedef enum logic [1:0] {
        OP_OTHER = 2'h0,
        OP_DIAG = 2'h1,
        OP_ACTIVE = 2'h2,
        OP_SAFE = 2'h3
    } op_state_e;

endpackage : selftest_launch_pkg

// ### test_launch_slot.sv
// One launch bit: start pulse, busy flag held until the engine reports completion
`timescale 1ns/1ns
module test_launch_slot (
    // Clock and resets
    input wire logic core_clk,
    input wire logic srst,
    input wire logic device_reset,
    // Accepted write of a one to this launch bit
    input wire logic launch,
    // Test engine answer
    input wire logic done,
    // Launch state
    output logic busy_q,
    output logic start_q,
    output logic finish_q
);

    // Busy from the launching write until the engine finishes
    always_ff @(posedge core_clk) begin
        if (srst || device_reset) begin
            busy_q <= 1'b0;
        end else if (!busy_q && launch) begin
            busy_q <= 1'b1;
        end else if (busy_q && done) begin
            busy_q <= 1'b0;
        end
    end

    // One-cycle start pulse towards the engine
    always_ff @(posedge core_clk) begin
        if (srst || device_reset) begin
            start_q <= 1'b0;
        end else begin
            start_q <= !busy_q && launch;
        end
    end

    // One-cycle completion pulse, aligned with the clearing of busy
    always_ff @(posedge core_clk) begin
        if (srst || device_reset) begin
            finish_q <= 1'b0;
        end else begin
            finish_q <= busy_q && done;
        end
    end

endmodule : test_launch_slot
